// ==== src/blanking_pkg.sv ====
// constants shared by the blanking shutdown supervisor files
`default_nettype none
package blanking_pkg;
	// ----------------------------------------------------------------
	// register map (word index on the plain register port)
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CTRL    = 4'h0;
	localparam logic [3:0] REG_MAXSIZE = 4'h1;
	localparam logic [3:0] REG_TOL     = 4'h2;
	localparam logic [3:0] REG_OBJNUM  = 4'h3;
	localparam logic [3:0] REG_DIR     = 4'h4;
	localparam logic [3:0] REG_STATUS  = 4'h5;
	localparam logic [3:0] REG_MASK    = 4'h6;
	localparam logic [3:0] REG_STATE   = 4'h7;
	localparam logic [3:0] REG_TAUGHT  = 4'h8;

	// ctrl bits
	localparam int CTRL_TEST_EN = 0;

	// status and mask bits, one per event
	localparam int EV_COUNT    = 0;
	localparam int EV_SIZE     = 1;
	localparam int EV_SPACING  = 2;
	localparam int EV_ENTRY    = 3;
	localparam int EV_SPEED    = 4;
	localparam int EV_COMPOUND = 5;
	localparam int EV_TEST     = 6;
	localparam int NEV         = 7;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_MAXSIZE = 16'h0078;
	localparam logic [15:0] RST_TOL     = 16'h003c;
	localparam logic [15:0] RST_OBJNUM  = 16'h0001;
	localparam logic [6:0]  RST_MASK    = 7'h00;

	// ----------------------------------------------------------------
	// geometry and timing
	// ----------------------------------------------------------------
	localparam int MARGIN_MM      = 10;
	localparam int SPEED_MAX_MMPS = 2500;
	localparam longint CLK_HZ     = 100_000_000;
	localparam int HOLD_MS        = 1000;
	localparam int HOLD_CYCLES    = HOLD_MS * int'(CLK_HZ / 1000);

	typedef enum logic [1:0] {
		DIR_FROM_DISPLAY,
		DIR_TOWARD_DISPLAY,
		DIR_BOTH
	} dir_t;
endpackage
`default_nettype wire

// ==== src/field_scanner.sv ====
// splits the blocked-beam vector into objects and measures them
`default_nettype none
module field_scanner #(
	parameter int NBEAMS = 64
) (
	// beam states, index 0 at the display end
	input  wire logic [NBEAMS-1:0] blocked,
	// object summary
	output logic      [7:0]        objCount,
	output logic      [7:0]        firstStart,
	output logic      [7:0]        secondStart,
	output logic      [7:0]        firstEnd,
	output logic      [7:0]        maxLen
);
	always_comb begin
		logic [7:0] run;
		logic       prev;
		run = 8'h00;
		prev = 1'b0;
		objCount = 8'h00;
		firstStart = 8'h00;
		secondStart = 8'h00;
		firstEnd = 8'h00;
		maxLen = 8'h00;
		for (int i = 0; i < NBEAMS; i++) begin
			if (blocked[i]) begin
				if (!prev) begin
					objCount = objCount + 8'h01;
					if (objCount == 8'h01)
						firstStart = 8'(i);
					if (objCount == 8'h02)
						secondStart = 8'(i);
					run = 8'h00;
				end
				run = run + 8'h01;
				if (run > maxLen)
					maxLen = run;
				if (objCount == 8'h01)
					firstEnd = 8'(i);
			end
			prev = blocked[i];
		end
	end
endmodule
`default_nettype wire

// ==== src/off_hold_timer.sv ====
// retriggerable minimum off-time for the safety outputs
`default_nettype none
module off_hold_timer #(
	parameter int CYCLES = 100_000_000
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// control
	input  wire logic trigger,
	output logic      holding
);
	logic [31:0] count;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count <= 32'h0;
		end else if (trigger) begin
			// a new violation restarts the full hold
			count <= 32'(CYCLES);
		end else if (count != 32'h0) begin
			count <= count - 32'h1;
		end
	end

	assign holding = trigger || (count != 32'h0);
endmodule
`default_nettype wire

// ==== src/blanking_shutdown_supervisor.sv ====
// self-teaching blanking supervisor driving the two safety outputs
`default_nettype none
module blanking_shutdown_supervisor
	import blanking_pkg::*;
#(
	parameter int NBEAMS      = 64,
	parameter int RES_MM      = 30,
	parameter int HOLD_CYCLES_P = blanking_pkg::HOLD_CYCLES
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rstn,
	// receiver beam states, one scan per strobe
	input  wire logic [NBEAMS-1:0] beamBlocked,
	input  wire logic              scanValid,
	// machine controller side
	input  wire logic              emitterTestN,
	input  wire logic              teachPress,
	output logic                   safetySwitchOutput1,
	output logic                   safetySwitchOutput2,
	output logic                   restartRequired,
	// emitter control
	output logic                   emitterOff,
	// register port
	input  wire logic [3:0]        addr,
	input  wire logic [15:0]       wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [15:0]       rdata,
	output logic                   irq
);
	import blanking_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [17:0] shutdownSize(input logic [15:0] maxSz,
			input logic [15:0] tol, input logic stationary);
		logic [17:0] s;
		s = 18'(maxSz) + 18'(tol) + 18'(MARGIN_MM);
		if (stationary)
			s = s + 18'(RES_MM);
		return s;
	endfunction

	function automatic logic [7:0] absDiff(input logic [7:0] a, input logic [7:0] b);
		return (a > b) ? a - b : b - a;
	endfunction

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic              testEnable;
	logic [15:0]       maxSize;
	logic [15:0]       tolerance;
	logic [7:0]        objNumber;
	dir_t              entryDir;
	logic [NEV-1:0]    status;
	logic [NEV-1:0]    mask;
	logic [15:0]       taughtSize;

	// ----------------------------------------------------------------
	// field analysis
	// ----------------------------------------------------------------
	logic [7:0] objCount;
	logic [7:0] firstStart;
	logic [7:0] secondStart;
	logic [7:0] firstEnd;
	logic [7:0] maxLen;

	field_scanner #(
		.NBEAMS(NBEAMS)
	) scanner (
		.blocked    (beamBlocked),
		.objCount   (objCount),
		.firstStart (firstStart),
		.secondStart(secondStart),
		.firstEnd   (firstEnd),
		.maxLen     (maxLen)
	);

	logic [7:0]  prevCount;
	logic [7:0]  prevStart;
	logic [7:0]  learnedSpacing;
	logic        spacingValid;
	logic [7:0]  peakCount;
	logic [31:0] cyclesSinceScan;

	logic [7:0]  spacing;
	logic [7:0]  moveBeams;
	logic        stationary;
	logic [17:0] objSizeMm;
	logic [NEV-1:0] events;
	logic        anyViolation;

	assign spacing = secondStart - firstEnd;
	assign moveBeams = absDiff(firstStart, prevStart);
	assign stationary = (prevCount != 8'h00) && (moveBeams == 8'h00);
	assign objSizeMm = 18'(maxLen) * 18'(RES_MM);

	// ----------------------------------------------------------------
	// emitter test
	// ----------------------------------------------------------------
	logic testActive;

	assign testActive = testEnable && !emitterTestN;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			emitterOff <= 1'b0;
		else
			emitterOff <= testActive;
	end

	// ----------------------------------------------------------------
	// violation detection
	// ----------------------------------------------------------------
	always_comb begin
		events = '0;
		if (scanValid) begin
			events[EV_COUNT] = objCount > objNumber;
			events[EV_SIZE] = (objCount != 8'h00) &&
				(objSizeMm >= shutdownSize(maxSize, tolerance, stationary));
			events[EV_SPACING] = spacingValid && (objCount >= 8'h02) &&
				(spacing != learnedSpacing);
			if (objCount > prevCount) begin
				case (entryDir)
					DIR_FROM_DISPLAY:   events[EV_ENTRY] = !beamBlocked[0];
					DIR_TOWARD_DISPLAY: events[EV_ENTRY] = !beamBlocked[NBEAMS-1];
					DIR_BOTH:           events[EV_ENTRY] =
						!beamBlocked[0] && !beamBlocked[NBEAMS-1];
					default:            events[EV_ENTRY] = 1'b1;
				endcase
			end
			// limit is cross-multiplied so no divider sits in the scan path
			// speed over the limit
			if ((objCount != 8'h00) && (objCount == prevCount))
				events[EV_SPEED] = (64'(moveBeams) * 64'(RES_MM) * 64'(CLK_HZ)) >
					(64'(SPEED_MAX_MMPS) * 64'(cyclesSinceScan));
			// compound passage with a single object
			events[EV_COMPOUND] = (objNumber > 8'h01) && (objCount == 8'h00) &&
				(prevCount != 8'h00) && (peakCount == 8'h01);
		end
		// test counts as a shutdown cause
		events[EV_TEST] = testActive;
	end

	assign anyViolation = |events;

	// ----------------------------------------------------------------
	// scan history and spacing learning
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prevCount <= 8'h00;
			prevStart <= 8'h00;
			peakCount <= 8'h00;
		end else if (scanValid) begin
			prevCount <= objCount;
			prevStart <= firstStart;
			if (objCount == 8'h00)
				peakCount <= 8'h00;
			else if (objCount > peakCount)
				peakCount <= objCount;
		end
	end

	// learn on entry, forget when fewer than two objects remain
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			learnedSpacing <= 8'h00;
			spacingValid <= 1'b0;
		end else if (scanValid) begin
			if (objCount < 8'h02) begin
				spacingValid <= 1'b0;
			end else if (!spacingValid) begin
				learnedSpacing <= spacing;
				spacingValid <= 1'b1;
			end
		end
	end

	// saturates so a long idle gap reads as slow, never wraps round to fast
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			cyclesSinceScan <= 32'h1;
		else if (scanValid)
			cyclesSinceScan <= 32'h1;
		else if (cyclesSinceScan != 32'hffffffff)
			cyclesSinceScan <= cyclesSinceScan + 32'h1;
	end

	// ----------------------------------------------------------------
	// output hold and restart interlock
	// ----------------------------------------------------------------
	logic holding;

	off_hold_timer #(
		.CYCLES(HOLD_CYCLES_P)
	) holdTimer (
		.clk    (clk),
		.rstn   (rstn),
		.trigger(anyViolation),
		.holding(holding)
	);

	// a press during the hold is refused so it cannot cut the off time short
	logic teachAccepted;

	assign teachAccepted = teachPress && !holding;

	// interlock set by a violation, cleared by teach
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			restartRequired <= 1'b0;
		else if (anyViolation)
			restartRequired <= 1'b1;
		else if (teachAccepted)
			restartRequired <= 1'b0;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			taughtSize <= 16'h0000;
		else if (teachAccepted)
			taughtSize <= objSizeMm[15:0];
	end

	// both outputs off while held or interlocked
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			safetySwitchOutput1 <= 1'b0;
			safetySwitchOutput2 <= 1'b0;
		end else begin
			safetySwitchOutput1 <= !holding && !restartRequired && !testActive;
			safetySwitchOutput2 <= !holding && !restartRequired && !testActive;
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// test enable off after reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			testEnable <= 1'b0;
		else if (wr && addr == REG_CTRL)
			testEnable <= wdata[CTRL_TEST_EN];
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			maxSize <= RST_MAXSIZE;
			tolerance <= RST_TOL;
			objNumber <= RST_OBJNUM[7:0];
			entryDir <= DIR_BOTH;
			mask <= RST_MASK;
		end else if (wr) begin
			case (addr)
				REG_MAXSIZE: maxSize <= wdata;
				REG_TOL:     tolerance <= wdata;
				REG_OBJNUM:  objNumber <= wdata[7:0];
				REG_DIR:     entryDir <= (wdata[1:0] == 2'h3) ? DIR_BOTH : dir_t'(wdata[1:0]);
				REG_MASK:    mask <= wdata[NEV-1:0];
				default:     ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// status, interrupt, read data
	// ----------------------------------------------------------------
	logic statusRead;

	assign statusRead = rd && (addr == REG_STATUS);

	// a new event in the clearing read survives: set wins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			status <= '0;
		else if (statusRead)
			status <= events;
		else
			status <= status | events;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			irq <= 1'b0;
		else
			irq <= |(status & mask);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 16'h0000;
		end else if (rd) begin
			case (addr)
				REG_CTRL:    rdata <= {15'h0, testEnable};
				REG_MAXSIZE: rdata <= maxSize;
				REG_TOL:     rdata <= tolerance;
				REG_OBJNUM:  rdata <= {8'h00, objNumber};
				REG_DIR:     rdata <= {14'h0, entryDir};
				REG_STATUS:  rdata <= {9'h0, status};
				REG_MASK:    rdata <= {9'h0, mask};
				REG_STATE:   rdata <= {objCount, 5'h0, restartRequired, holding, emitterOff};
				REG_TAUGHT:  rdata <= taughtSize;
				default:     rdata <= 16'h0000;
			endcase
		end else begin
			rdata <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

// ==== bench/blanking_assertions.sv ====
// concurrent checks on the blanking supervisor ports
`default_nettype none
module blanking_checker #(
	parameter int HOLD_CYCLES_P = 20
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// inputs seen by the supervisor
	input wire logic        scanValid,
	input wire logic        emitterTestN,
	input wire logic        teachPress,
	input wire logic        rd,
	// outputs of the supervisor
	input wire logic        safetySwitchOutput1,
	input wire logic        safetySwitchOutput2,
	input wire logic        restartRequired,
	input wire logic        emitterOff,
	input wire logic [15:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] offRun;
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// ----------------------------------------------------------------
	// off time while the interlock is set; zero after power-up release
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			offRun <= 32'h0;
		end else if (safetySwitchOutput1) begin
			offRun <= 32'h0;
		end else if (restartRequired) begin
			offRun <= offRun + 32'h1;
		end
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_pair;
		safetySwitchOutput1 == safetySwitchOutput2;
	endproperty
	a_pair: assert property (p_pair) else $error("safety outputs disagree");
	property p_cause;
		$rose(restartRequired) |-> $past(scanValid) || !$past(emitterTestN);
	endproperty
	a_cause: assert property (p_cause) else $error("trip without scan or test");
	property p_drop;
		restartRequired |-> !safetySwitchOutput1 && !safetySwitchOutput2;
	endproperty
	a_drop: assert property (p_drop) else $error("outputs on with interlock set");
	property p_hold;
		$rose(safetySwitchOutput1) |-> offRun == 32'h0 || offRun >= HOLD_CYCLES_P;
	endproperty
	a_hold: assert property (p_hold) else $error("off time shorter than hold");
	property p_test_off;
		emitterOff |-> !safetySwitchOutput1;
	endproperty
	a_test_off: assert property (p_test_off) else $error("outputs on during test");
	property p_test_idle;
		emitterTestN |=> !emitterOff;
	endproperty
	a_test_idle: assert property (p_test_idle) else $error("emitter off without request");
	property p_teach;
		$fell(restartRequired) |-> $past(teachPress);
	endproperty
	a_teach: assert property (p_teach) else $error("interlock cleared without teach");
	property p_rdata_idle;
		!$past(rd) |-> rdata == 16'h0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
	c_trip: cover property ($rose(restartRequired));
	c_test: cover property ($rose(emitterOff));
	c_rearm: cover property ($fell(restartRequired));
endmodule
`default_nettype wire

// ==== bench/machine_ctrl_model.sv ====
// machine controller model: drives test and teach lines, reads outputs
`default_nettype none
module machine_ctrl_model (
	// clock and reset
	input wire logic  clk,
	input wire logic  rstn,
	// commands from the bench
	input wire logic  testReq,
	input wire logic  teachReq,
	// safety outputs, each channel read on its own
	input wire logic  safetySwitchOutput1,
	input wire logic  safetySwitchOutput2,
	// lines towards the supervisor, split flag to the bench
	output logic      emitterTestN,
	output logic      teachPress,
	output logic      outputsSplit
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			emitterTestN <= 1'b1;
		end else begin
			emitterTestN <= !testReq;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			teachPress <= 1'b0;
		end else begin
			teachPress <= teachReq;
		end
	end
	// sticky: a channel mismatch must never be missed between checks
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			outputsSplit <= 1'b0;
		end else if (safetySwitchOutput1 != safetySwitchOutput2) begin
			outputsSplit <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== bench/blanking_shutdown_supervisor_test.sv ====
// self-checking bench for the blanking shutdown supervisor
`default_nettype none
module blanking_shutdown_supervisor_test;
	timeunit 1ns;
	timeprecision 1ps;
	import blanking_pkg::*;
	localparam int HOLD = 20;
	localparam int RES  = 30;
	logic        clk, rstn, scanValid, wr, rd, testReq, teachReq, emitterTestN, teachPress;
	logic        out1, out2, restartRequired, emitterOff, irq, outputsSplit;
	logic [63:0] beamBlocked;
	logic [3:0]  addr;
	logic [15:0] wdata, rdata, got;
	logic [31:0] seed;
	int          bad_count, total_checks, n, maxs;
	logic [15:0] rstVal [5] = '{16'h0, RST_MAXSIZE, RST_TOL, RST_OBJNUM, 16'h2};
	logic [63:0] entryVec [3] = '{64'hc000_0000_0000_0000, 64'h3, 64'h0000_0000_0070_0000};

	blanking_shutdown_supervisor #(.NBEAMS(64), .RES_MM(RES), .HOLD_CYCLES_P(HOLD)) dut (
		.clk(clk), .rstn(rstn), .beamBlocked(beamBlocked), .scanValid(scanValid),
		.emitterTestN(emitterTestN), .teachPress(teachPress), .safetySwitchOutput1(out1),
		.safetySwitchOutput2(out2), .restartRequired(restartRequired),
		.emitterOff(emitterOff), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .irq(irq));
	machine_ctrl_model partner (
		.clk(clk), .rstn(rstn), .testReq(testReq), .teachReq(teachReq),
		.safetySwitchOutput1(out1), .safetySwitchOutput2(out2),
		.emitterTestN(emitterTestN), .teachPress(teachPress), .outputsSplit(outputsSplit));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic int sizeThr(input int mx, input int tol, input bit still);
		return mx + tol + MARGIN_MM + (still ? RES : 0);
	endfunction
	function automatic logic [63:0] run(input int len);
		return (64'h1 << len) - 64'h1;
	endfunction
	task automatic check(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 got = rdata;
	endtask
	task automatic scan(input logic [63:0] v);
		@(posedge clk);
		beamBlocked <= v;
		scanValid <= 1'b1;
		@(posedge clk);
		scanValid <= 1'b0;
	endtask
	task automatic press();
		@(posedge clk);
		teachReq <= 1'b1;
		@(posedge clk);
		teachReq <= 1'b0;
	endtask
	task automatic tripped(input int b);
		#1 check({14'h0, out2, out1}, 16'h0);
		check({15'h0, restartRequired}, 16'h1);
		rreg(REG_STATUS);
		check({15'h0, got[b]}, 16'h1);
	endtask
	// empties the field, waits out the hold and re-arms by teach
	task automatic recover();
		wreg(REG_OBJNUM, 16'h1);
		scan(64'h0);
		repeat (HOLD + 2) @(posedge clk);
		press();
		repeat (4) @(posedge clk);
		#1 check({14'h0, out2, out1}, 16'h3);
		rreg(REG_STATUS);
	endtask
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// clock, watchdog, sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		complete_run();
	end
	initial begin
		{rstn, scanValid, wr, rd, testReq, teachReq} = 6'h0;
		{beamBlocked, addr, wdata} = '0;
		seed = 32'h5624b911;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rreg(i[3:0]);
			check(got, rstVal[i]);
		end
		rreg(REG_MASK);
		check(got, {9'h0, RST_MASK});
		rreg(4'hf);
		check(got, 16'h0);
		wreg(REG_DIR, 16'h3);
		rreg(REG_DIR);
		check(got, 16'h2);
		// random maximum size; grow a stationary object across the boundary
		seed = xs(seed);
		maxs = 60 + int'(seed[2:0]) * 30;
		n = (sizeThr(maxs, int'(RST_TOL), 1'b1) + RES - 1) / RES;
		wreg(REG_MAXSIZE, 16'(maxs));
		scan(64'h1);
		scan(run(n - 1));
		#1 check({14'h0, out2, out1}, 16'h3);
		scan(run(n));
		tripped(EV_SIZE);
		repeat (HOLD - 6) @(posedge clk);
		scan(run(n));
		repeat (8) @(posedge clk);
		press();
		repeat (4) @(posedge clk);
		#1 check({15'h0, restartRequired}, 16'h1);
		rreg(REG_TAUGHT);
		check(got, 16'h0);
		recover();
		// fresh entry is judged as moving, so one beam less already trips
		scan(run(n - 1));
		tripped(EV_SIZE);
		repeat (HOLD) @(posedge clk);
		press();
		rreg(REG_TAUGHT);
		check(got, 16'((n - 1) * RES));
		recover();
		// too many objects, unmasked event raises irq
		wreg(REG_MASK, 16'h1);
		scan({2'b11, 60'h0, 2'b11});
		@(posedge clk);
		#1 check({15'h0, irq}, 16'h1);
		tripped(EV_COUNT);
		@(posedge clk);
		#1 check({15'h0, irq}, 16'h0);
		wreg(REG_MASK, 16'h0);
		recover();
		// wrong entry edge for every direction mode
		for (int i = 0; i < 3; i++) begin
			wreg(REG_DIR, 16'(i));
			scan(entryVec[i]);
			tripped(EV_ENTRY);
			check({15'h0, irq}, 16'h0);
			recover();
		end
		wreg(REG_DIR, 16'h2);
		scan(64'h7);
		scan(64'he);
		tripped(EV_SPEED);
		recover();
		wreg(REG_OBJNUM, 16'h2);
		scan({2'b11, 60'h0, 2'b11});
		#1 check({14'h0, out2, out1}, 16'h3);
		scan({3'b111, 59'h0, 2'b11});
		tripped(EV_SPACING);
		recover();
		wreg(REG_OBJNUM, 16'h2);
		scan(64'h7);
		scan(64'h0);
		tripped(EV_COMPOUND);
		recover();
		// emitter test: ignored while disabled, then honoured
		@(posedge clk);
		testReq <= 1'b1;
		repeat (4) @(posedge clk);
		#1 check({14'h0, emitterOff, out1}, 16'h1);
		wreg(REG_CTRL, 16'h1);
		repeat (3) @(posedge clk);
		#1 check({15'h0, emitterOff}, 16'h1);
		tripped(EV_TEST);
		rreg(REG_STATE);
		check(got, 16'h0007);
		@(posedge clk);
		testReq <= 1'b0;
		recover();
		check({15'h0, outputsSplit}, 16'h0);
		complete_run();
	end
endmodule

bind blanking_shutdown_supervisor blanking_checker #(.HOLD_CYCLES_P(HOLD_CYCLES_P)) chk (
	.clk(clk), .rstn(rstn), .scanValid(scanValid), .emitterTestN(emitterTestN),
	.teachPress(teachPress), .rd(rd), .safetySwitchOutput1(safetySwitchOutput1),
	.safetySwitchOutput2(safetySwitchOutput2), .restartRequired(restartRequired),
	.emitterOff(emitterOff), .rdata(rdata));
`default_nettype wire
